//--- xpt_ctrl_regs.svh
// Register offsets, fields and timing counts for the crosspoint host controller
`ifndef XPT_CTRL_REGS_SVH
`define XPT_CTRL_REGS_SVH

// AXI4-Lite byte offsets of the controller registers
`define OFS_CMD 4'h0
`define OFS_DATA 4'h4
`define OFS_STATUS 4'h8
`define OFS_RDATA 4'hC

// Command register fields
`define CMD_INDEX_LSB 0
`define CMD_BANK_BIT 6
`define CMD_OP_LSB 8
`define CMD_OP_W 3

// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1

// Device figures
`define NUM_OUTPUTS 6'h22
`define BROADCAST_INDEX 6'h3F
`define DISABLE_CODE 6'h3F
`define RESET_CURRENT_CODE 4'h7

// Strobe timing, ns and cycles at 40 ns
`define CLK_PERIOD_NS 40
`define STROBE_NS 80
`define SETUP_NS 40
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_NS 200
`define RESET_CYC ((`RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- xpt_ctrl_pkg.sv
// Types shared by the crosspoint host controller
package xpt_ctrl_pkg;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_WRITE = 3'h1,
      OP_UPDATE = 3'h2,
      OP_READ = 3'h3,
      OP_RESET = 3'h4
   } op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD = 3'b011,
      ST_DONE = 3'b100
   } state_t;
endpackage : xpt_ctrl_pkg

//--- axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module axil_slave (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_stb,
   output logic [3:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_be,
   output logic rd_stb,
   output logic [3:0] rd_addr,
   input wire logic [31:0] rd_value,
   input wire logic rd_ok
);
   logic aw_ff, w_ff, b_ff, r_ff;
   logic [3:0] awa_ff;
   logic [31:0] wd_ff;
   logic [3:0] ws_ff;
   logic [31:0] rd_ff;
   logic [1:0] rr_ff;

   // Accept each channel independently until it is held; both stay closed until the response is taken
   assign awready = !aw_ff && !b_ff;
   assign wready = !w_ff && !b_ff;
   assign arready = !r_ff;
   assign wr_stb = aw_ff && w_ff && !b_ff;
   assign wr_addr = awa_ff;
   assign wr_data = wd_ff;
   assign wr_be = ws_ff;
   assign rd_stb = arvalid && arready;
   assign rd_addr = araddr;
   assign bresp = 2'h0;
   assign bvalid = b_ff;
   assign rvalid = r_ff;
   assign rdata = rd_ff;
   assign rresp = rr_ff;

   // Write path
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         b_ff <= 1'b0;
         awa_ff <= 4'h0;
         wd_ff <= 32'h0;
         ws_ff <= 4'h0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_ff <= 1'b1;
            awa_ff <= awaddr;
         end
         if (wvalid && wready) begin
            w_ff <= 1'b1;
            wd_ff <= wdata;
            ws_ff <= wstrb;
         end
         if (wr_stb) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            b_ff <= 1'b1;
         end
         if (b_ff && bready) b_ff <= 1'b0;
      end
   end

   // Read path, data sampled at address acceptance
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_ff <= 1'b0;
         rd_ff <= 32'h0;
         rr_ff <= 2'h0;
      end else if (ce) begin
         if (rd_stb) begin
            r_ff <= 1'b1;
            rd_ff <= rd_value;
            rr_ff <= rd_ok ? 2'h0 : 2'h2;
         end else if (r_ff && rready) begin
            r_ff <= 1'b0;
         end
      end
   end
endmodule : axil_slave

//--- xpt_host_ctrl.sv
// Host controller driving the crosspoint parallel control port
`timescale 1ns/1ps
`include "xpt_ctrl_regs.svh"
module xpt_host_ctrl
   import xpt_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic [5:0] output_index,
   output logic bank_select_bit,
   input wire logic [5:0] config_data_bus_in,
   output logic [5:0] config_data_bus_out,
   output logic config_data_bus_oe,
   output logic chip_select_n,
   output logic write_enable_n,
   output logic update_n,
   output logic readback_enable_n,
   output logic reset_n_pin
);
   state_t state_ff, nxt_state;
   op_t op_ff;
   logic [2:0] cnt_ff;
   logic [5:0] idx_ff;
   logic bank_ff;
   logic [5:0] data_ff;
   logic [5:0] rb_ff;
   logic err_ff;
   logic [2:0] por_ff;
   logic wr_stb, rd_stb;
   logic [3:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_value;
   logic [3:0] wr_be;
   logic rd_ok;

   axil_slave u_bus (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_be(wr_be),
      .rd_stb(rd_stb),
      .rd_addr(rd_addr),
      .rd_value(rd_value),
      .rd_ok(rd_ok)
   );

   // Register decode
   wire busy = (state_ff != ST_IDLE);
   wire cmd_hit = wr_stb && (wr_addr == `OFS_CMD) && wr_be[1];
   wire data_hit = wr_stb && (wr_addr == `OFS_DATA) && wr_be[0];
   wire op_t new_op = op_t'(wr_data[`CMD_OP_LSB +: `CMD_OP_W]);
   wire [5:0] new_idx = wr_data[`CMD_INDEX_LSB +: 6];
   wire new_bank = wr_data[`CMD_BANK_BIT];
   // Reserved indices are refused for write and read commands only
   wire idx_reserved = (new_idx >= `NUM_OUTPUTS) && (new_idx != `BROADCAST_INDEX);
   // Broadcast readback is refused here
   wire bad_read = (new_op == OP_READ) && (new_idx == `BROADCAST_INDEX);
   wire op_known = (new_op == OP_WRITE) || (new_op == OP_UPDATE) ||
                   (new_op == OP_READ) || (new_op == OP_RESET);
   wire needs_idx = (new_op == OP_WRITE) || (new_op == OP_READ);
   wire reject = !op_known || bad_read || (needs_idx && idx_reserved);
   wire start = cmd_hit && !busy && !reject;
   wire refuse = cmd_hit && (busy || reject);

   assign rd_ok = (rd_addr == `OFS_CMD) || (rd_addr == `OFS_DATA) ||
                  (rd_addr == `OFS_STATUS) || (rd_addr == `OFS_RDATA);
   assign rd_value = (rd_addr == `OFS_CMD) ?
                        {21'h0, op_ff, 1'b0, bank_ff, idx_ff} :
                     (rd_addr == `OFS_DATA) ? {26'h0, data_ff} :
                     (rd_addr == `OFS_STATUS) ? {30'h0, err_ff, busy} :
                     (rd_addr == `OFS_RDATA) ? {26'h0, rb_ff} : 32'h0;

   // Strobe sequencer: setup, strobe low, hold
   wire cnt_done = (cnt_ff == 3'h0);
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (start) nxt_state = ST_SETUP;
         ST_SETUP: if (cnt_done) nxt_state = ST_STROBE;
         ST_STROBE: if (cnt_done) nxt_state = ST_HOLD;
         ST_HOLD: if (cnt_done) nxt_state = ST_DONE;
         ST_DONE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   wire strobing = (state_ff == ST_STROBE);
   wire active = (state_ff == ST_SETUP) || strobing || (state_ff == ST_HOLD);
   wire is_read = (op_ff == OP_READ);
   // Select only around the access; reset pin needs no select
   wire nxt_cs_n = !(active && (op_ff != OP_RESET));
   // Write strobe pulsed then returned high
   wire nxt_we_n = !(strobing && (op_ff == OP_WRITE));
   wire nxt_upd_n = !(strobing && (op_ff == OP_UPDATE));
   // Readback held across setup and hold, never with write strobe
   wire nxt_re_n = !(active && is_read);
   // Release data bus while reading
   wire nxt_oe = active && (op_ff == OP_WRITE);
   wire nxt_rst = !(strobing && (op_ff == OP_RESET));
   wire [2:0] nxt_cnt = (state_ff == ST_IDLE) ? 3'(`SETUP_CYC - 1) :
                        (state_ff == ST_SETUP && cnt_done) ?
                           3'(`STROBE_CYC - 1) :
                        (state_ff == ST_STROBE && cnt_done) ?
                           3'(`SETUP_CYC - 1) :
                        cnt_done ? 3'h0 : cnt_ff - 3'h1;

   // Sequencer and command state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 3'h0;
         op_ff <= OP_NONE;
         idx_ff <= 6'h0;
         bank_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         if (start) begin
            op_ff <= new_op;
            idx_ff <= new_idx;
            bank_ff <= new_bank;
         end
      end
   end

   // Data word, high bit most significant
   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_ff <= `DISABLE_CODE;
      end else if (ce && data_hit && !busy) begin
         data_ff <= wr_data[5:0];
      end
   end

   // Readback capture at end of strobe and error flag; set beats clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rb_ff <= 6'h0;
         err_ff <= 1'b0;
      end else if (ce) begin
         if (strobing && cnt_done && is_read) rb_ff <= config_data_bus_in;
         if (refuse) err_ff <= 1'b1;
         else if (start) err_ff <= 1'b0;
      end
   end

   // Device pins from flops; reset pin pulsed after controller reset
   // The pulse also clears both ranks; commands are not held off until it ends
   always_ff @(posedge clk) begin
      if (!resetn) begin
         chip_select_n <= 1'b1;
         write_enable_n <= 1'b1;
         update_n <= 1'b1;
         readback_enable_n <= 1'b1;
         config_data_bus_oe <= 1'b0;
         config_data_bus_out <= 6'h0;
         output_index <= 6'h0;
         bank_select_bit <= 1'b0;
         reset_n_pin <= 1'b0;
         por_ff <= 3'(`RESET_CYC);
      end else if (ce) begin
         chip_select_n <= nxt_cs_n;
         write_enable_n <= nxt_we_n;
         update_n <= nxt_upd_n;
         readback_enable_n <= nxt_re_n;
         config_data_bus_oe <= nxt_oe;
         config_data_bus_out <= data_ff;
         output_index <= idx_ff;
         bank_select_bit <= bank_ff;
         if (por_ff != 3'h0) por_ff <= por_ff - 3'h1;
         reset_n_pin <= (por_ff == 3'h0) && nxt_rst;
      end
   end
endmodule : xpt_host_ctrl

//--- xpt_host_ctrl_properties.sv
// Concurrent checks on the controller's device-side pins
`timescale 1ns/1ps
module xpt_host_ctrl_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [5:0] output_index,
   input wire logic bank_select_bit,
   input wire logic [5:0] config_data_bus_out,
   input wire logic config_data_bus_oe,
   input wire logic chip_select_n,
   input wire logic write_enable_n,
   input wire logic update_n,
   input wire logic readback_enable_n,
   input wire logic reset_n_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Write strobe: two cycles low, then back high
   sequence strobe_two_s;
      !write_enable_n [*2] ##1 write_enable_n;
   endsequence

   wr_release_a: assert property (
      $fell(write_enable_n) |-> strobe_two_s)
      else $error("write strobe not released after two cycles");
   wr_select_a: assert property (
      $fell(write_enable_n) |-> $past(chip_select_n) == 1'b0)
      else $error("select not low ahead of write strobe");
   wr_data_a: assert property (
      !write_enable_n |-> config_data_bus_oe && $stable(config_data_bus_out)
         && $stable(bank_select_bit))
      else $error("write data moved under strobe");
   rb_release_a: assert property (
      !readback_enable_n |-> !config_data_bus_oe)
      else $error("bus driven during readback");
   strobe_cs_a: assert property (
      (!write_enable_n || !update_n || !readback_enable_n) |-> !chip_select_n)
      else $error("strobe without select");
   one_strobe_a: assert property (
      $onehot0({!write_enable_n, !update_n, !readback_enable_n}))
      else $error("two strobes low together");
   wr_index_a: assert property (
      !write_enable_n |-> output_index < 6'h22 || output_index == 6'h3F)
      else $error("write to reserved index");
   rb_index_a: assert property (
      !readback_enable_n |-> output_index < 6'h22)
      else $error("readback of broadcast or reserved index");
   pwr_reset_a: assert property (
      $rose(resetn) |-> !reset_n_pin [*4])
      else $error("power-up reset pulse too short");
   rst_quiet_a: assert property (
      !reset_n_pin |-> chip_select_n && write_enable_n)
      else $error("select or write during reset pulse");
endmodule : xpt_host_ctrl_checker

bind xpt_host_ctrl xpt_host_ctrl_checker u_chk (.clk, .resetn,
   .output_index, .bank_select_bit, .config_data_bus_out,
   .config_data_bus_oe, .chip_select_n, .write_enable_n, .update_n,
   .readback_enable_n, .reset_n_pin);

//--- xpt_port_model.sv
// Behavioural model of the crosspoint control port with both ranks
`timescale 1ns/1ps
module xpt_port_model (
   input wire logic clk,
   input wire logic [5:0] output_index,
   input wire logic bank_select_bit,
   input wire logic [5:0] host_data,
   input wire logic host_oe,
   input wire logic chip_select_n,
   input wire logic write_enable_n,
   input wire logic update_n,
   input wire logic readback_enable_n,
   input wire logic reset_n_pin,
   output logic [5:0] bus_level
);
   logic [5:0] conn1 [34];
   logic [5:0] conn2 [34];
   logic [3:0] cur1 [34];
   logic [3:0] cur2 [34];
   logic [5:0] last_ff;
   logic rb_oe;
   logic [5:0] rb_val;
   logic [5:0] ma_out0;
   logic off_out33;

   // Level-sensitive latches; each action lasts while its strobe is low
   always_latch begin
      if (!reset_n_pin) begin
         for (int i = 0; i < 34; i++) begin
            conn1[i] = 6'h3F;
            conn2[i] = 6'h3F;
            cur1[i] = 4'h7;
            cur2[i] = 4'h7;
         end
      end else if (!chip_select_n) begin
         if (!write_enable_n && readback_enable_n) begin
            for (int i = 0; i < 34; i++) begin
               if (output_index == 6'h3F || output_index == i) begin
                  if (bank_select_bit) cur1[i] = host_data[3:0];
                  else conn1[i] = host_data;
               end
            end
         end
         if (!update_n) begin
            conn2 = conn1;
            cur2 = cur1;
         end
      end
   end

   // Readback; out-of-range index gives a harmless zero
   assign rb_oe = !chip_select_n && !readback_enable_n;
   assign rb_val = (output_index > 6'h21) ? 6'h00 :
      bank_select_bit ? {2'b00, cur2[output_index]} : conn2[output_index];
   // Undriven bus toggles so a stale value cannot pass as read data
   assign bus_level = host_oe ? host_data : rb_oe ? rb_val : ~last_ff;
   always_ff @(posedge clk) last_ff <= bus_level;

   // Output current in mA and disable state, from second rank only
   assign ma_out0 = {1'b0, cur2[0], 1'b0} + 6'h02;
   assign off_out33 = (conn2[33] == 6'h3F);
endmodule : xpt_port_model

//--- xpt_host_ctrl_tb.sv
// Self-checking bench for the crosspoint host controller
`timescale 1ns/1ps
module xpt_host_ctrl_tb
   import xpt_ctrl_pkg::*;
;
   logic clk = 1'b0;
   logic resetn, ce, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [5:0] output_index, config_data_bus_out, config_data_bus_in;
   logic bank_select_bit, config_data_bus_oe, chip_select_n, write_enable_n;
   logic update_n, readback_enable_n, reset_n_pin;
   int failures = 0;
   int n_checks = 0;

   always #20 clk = ~clk;

   xpt_host_ctrl u_dut (.clk, .resetn, .ce, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .output_index,
      .bank_select_bit, .config_data_bus_in, .config_data_bus_out,
      .config_data_bus_oe, .chip_select_n, .write_enable_n, .update_n,
      .readback_enable_n, .reset_n_pin);
   xpt_port_model u_dev (.clk, .output_index, .bank_select_bit,
      .host_data(config_data_bus_out), .host_oe(config_data_bus_oe),
      .chip_select_n, .write_enable_n, .update_n, .readback_enable_n,
      .reset_n_pin, .bus_level(config_data_bus_in));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Address and data offered together, each dropped once taken
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      check({30'h0, bresp}, 32'h0);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // Issue one device operation and poll until idle; rd keeps status
   task automatic do_op(input logic [2:0] op, input logic bank,
      input logic [5:0] idx, input logic [5:0] d);
      axi_write(4'h4, {26'h0, d});
      axi_write(4'h0, {21'h0, op, 1'b0, bank, idx});
      rd = 32'h1;
      while (rd[0] !== 1'b0) axi_read(4'h8, rd, rs);
   endtask : do_op

   task automatic rdback(input logic bank, input logic [5:0] idx,
      input logic [5:0] exp);
      do_op(OP_READ, bank, idx, 6'h00);
      axi_read(4'hC, rd, rs);
      check(rd, {26'h0, exp});
   endtask : rdback

   task automatic chk_all(input logic [5:0] c, input logic [3:0] k);
      for (int i = 0; i < 34; i++) begin
         check({26'h0, u_dev.conn2[i]}, {26'h0, c});
         check({28'h0, u_dev.cur2[i]}, {28'h0, k});
      end
   endtask : chk_all

   task automatic report_and_stop();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 40'h0;
      ce = 1'b1;
      wstrb = 4'hF;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
      chk_all(6'h3F, 4'h7);
      check({26'h0, u_dev.ma_out0}, 32'h10);
      do_op(OP_WRITE, 1'b0, 6'h3F, 6'h05);
      do_op(OP_WRITE, 1'b1, 6'h3F, 6'h03);
      check({26'h0, u_dev.conn2[0]}, 32'h3F);
      do_op(OP_UPDATE, 1'b0, 6'h00, 6'h00);
      chk_all(6'h05, 4'h3);
      // Clock enable low mid-operation freezes the strobe sequence
      axi_write(4'h4, 32'h0C);
      axi_write(4'h0, {21'h0, OP_WRITE, 2'h0, 6'h21});
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      check({30'h0, chip_select_n, write_enable_n}, 32'h1);
      check({26'h0, u_dev.conn1[33]}, 32'h05);
      ce <= 1'b1;
      rd = 32'h1;
      while (rd[0] !== 1'b0) axi_read(4'h8, rd, rs);
      rdback(1'b0, 6'h21, 6'h05);
      do_op(OP_UPDATE, 1'b0, 6'h00, 6'h00);
      rdback(1'b0, 6'h21, 6'h0C);
      rdback(1'b0, 6'h00, 6'h05);
      do_op(OP_WRITE, 1'b1, 6'h00, 6'h3A);
      do_op(OP_UPDATE, 1'b0, 6'h00, 6'h00);
      rdback(1'b1, 6'h00, 6'h0A);
      check({28'h0, u_dev.cur2[1]}, 32'h3);
      check({26'h0, u_dev.ma_out0}, 32'h16);
      do_op(OP_WRITE, 1'b0, 6'h22, 6'h00);
      check(rd, 32'h2);
      check({26'h0, u_dev.conn1[0]}, 32'h05);
      do_op(OP_READ, 1'b0, 6'h3F, 6'h00);
      check(rd, 32'h2);
      do_op(3'h7, 1'b0, 6'h00, 6'h00);
      check(rd, 32'h2);
      do_op(OP_WRITE, 1'b0, 6'h21, 6'h3F);
      check(rd, 32'h0);
      do_op(OP_UPDATE, 1'b0, 6'h00, 6'h00);
      check({26'h0, u_dev.conn2[33]}, 32'h3F);
      check({31'h0, u_dev.off_out33}, 32'h1);
      axi_read(4'h2, rd, rs);
      check({30'h0, rs}, 32'h2);
      do_op(OP_RESET, 1'b0, 6'h00, 6'h00);
      chk_all(6'h3F, 4'h7);
      report_and_stop();
   end

   // Watchdog: the sequence needs far fewer than 20000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop();
   end
endmodule : xpt_host_ctrl_tb
